// [verilog/pms_phy_mgmt_regs.vh]
// Constants for the per-port PHY management status and negotiation registers
`ifndef PMS_PHY_MGMT_REGS_VH
`define PMS_PHY_MGMT_REGS_VH

// Register numbers on the management interface
`define PMS_REG_BASIC_STATUS   5'h01
`define PMS_REG_IDENT_UPPER    5'h02
`define PMS_REG_IDENT_LOWER    5'h03
`define PMS_REG_NEG_ADVERT     5'h04
`define PMS_REG_PARTNER        5'h05

// PHY addresses of the two copper ports
`define PMS_PHY_ADDR_PORT1     5'h01
`define PMS_PHY_ADDR_PORT2     5'h02

// Identifier words, values are arbitrary
`define PMS_IDENT_UPPER_VAL    16'h5a5a
`define PMS_IDENT_LOWER_VAL    16'h0c3e

// Basic status fixed fields
`define PMS_BS_FOUR_PAIR       1'b0
`define PMS_BS_SPEED_ABILITY   4'hf
`define PMS_BS_RESERVED        4'h0

// Advertisement layout
`define PMS_ADV_PAUSE_BIT      10
`define PMS_ADV_ABIL_HI        8
`define PMS_ADV_ABIL_LO        5
`define PMS_ADV_SELECTOR       5'h01
`define PMS_ADV_BITS_RST       5'h1f

// Port status register bits (first status register of a port)
`define PMS_ST_NEG_DONE        6
`define PMS_ST_LINK            5
`define PMS_ST_PAUSE           4
`define PMS_ST_ABIL_HI         3
`define PMS_ST_WIDTH           7
`define PMS_ST_RST             7'h00

// Mirror reset values
`define PMS_NEG_ABILITY_RST    1'b1
`define PMS_FAR_FAULT_RST      1'b0

`endif

// [verilog/pms_port_regs.v]
// Per-port mirror and advertisement storage for the PHY management registers
`timescale 1ns/1ns
`default_nettype none
`include "pms_phy_mgmt_regs.vh"

module pms_port_regs (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Management write of the advertisement register
  input  wire        i_adv_wr,
  input  wire [15:0] i_adv_wdata,
  // Port control side update of the advertised bits
  input  wire        i_ctl_wr,
  input  wire [4:0]  i_ctl_adv,
  // Port status mirrors
  input  wire [6:0]  i_status,
  input  wire        i_far_end_fault,
  input  wire        i_neg_ability,
  // Register images
  output wire [15:0] o_basic_status,
  output wire [15:0] o_adv_reg,
  output wire [15:0] o_partner_reg,
  output reg  [4:0]  o_adv_bits,
  output reg         o_adv_wr
);

  reg [6:0] status_reg;
  reg       far_fault_reg;
  reg       neg_ability_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mirrored status bits, registered copies
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg      <= `PMS_ST_RST;          // R4 R10 R11
      far_fault_reg   <= `PMS_FAR_FAULT_RST;   // R5
      neg_ability_reg <= `PMS_NEG_ABILITY_RST; // R6
    end else begin
      status_reg      <= i_status;
      far_fault_reg   <= i_far_end_fault;      // R5
      neg_ability_reg <= i_neg_ability;        // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertised bits; port control update wins a same-cycle collision
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_adv_bits <= `PMS_ADV_BITS_RST;         // R8 R9
      o_adv_wr   <= 1'b0;
    end else begin
      o_adv_wr <= i_adv_wr & ~i_ctl_wr;        // R8
      if (i_ctl_wr) begin
        o_adv_bits <= i_ctl_adv;               // R8
      end else if (i_adv_wr) begin
        o_adv_bits <= {i_adv_wdata[`PMS_ADV_PAUSE_BIT],
                       i_adv_wdata[`PMS_ADV_ABIL_HI:`PMS_ADV_ABIL_LO]}; // R9 R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register images
  assign o_basic_status = {`PMS_BS_FOUR_PAIR,                 // R1
                           `PMS_BS_SPEED_ABILITY,             // R2
                           `PMS_BS_RESERVED, 1'b0,            // R3
                           status_reg[`PMS_ST_NEG_DONE],      // R4
                           far_fault_reg,                     // R5
                           neg_ability_reg,                   // R6
                           status_reg[`PMS_ST_LINK],          // R12
                           1'b0, 1'b0};                       // R3
  assign o_adv_reg      = {5'h00, o_adv_bits[4], 1'b0,        // R13
                           o_adv_bits[3:0],
                           `PMS_ADV_SELECTOR};                // R12
  assign o_partner_reg  = {5'h00,                             // R13
                           status_reg[`PMS_ST_PAUSE], 1'b0,   // R10
                           status_reg[`PMS_ST_ABIL_HI:0],     // R11
                           5'h00};

endmodule // pms_port_regs

`default_nettype wire

// [verilog/pms_phy_mgmt_status_regs.v]
// PHY management status, identifier, advertisement and partner registers
`timescale 1ns/1ns
`default_nettype none
`include "pms_phy_mgmt_regs.vh"

// What this block does
// [R1] Basic status bit 15 reads 0: no four-pair ability.
// [R2] Basic status bits 14 to 11 always read 1.
// [R3] Basic status bits 10..6, 1 and 0 read 0.
// [R4] Basic status bit 5 copies port status bit 6, reset 0.
// [R5] Basic status bit 4 shows far-end fault, reset 0.
// [R6] Basic status bit 3 copies port control bit 7, reset 1.
// [R7] Registers 2 and 3 hold fixed upper and lower identifier words.
// [R8] Advertisement bit 10 writable, reset 1, kept consistent with port control bit 4.
// [R9] Advertisement bits 8..5 writable, reset 1, match port control bits 3..0.
// [R10] Partner bit 10 copies port status bit 4, reset 0.
// [R11] Partner bits 8..5 copy port status bits 3..0, reset 0.
// [R12] Basic status bit 2 is link; advertisement selector reads 00001.
// [R13] Unsupported and reserved fields read 0; writes to them are dropped.
// [R14] Station uses PHY address 1 for port 1 and 2 for port 2.
// [R15] In center-side mode only port 1 answers, at its programmed address.
module pms_phy_mgmt_status_regs #(
  parameter NUM_PORTS = 2
) (
  // Clock and reset
  input  wire                   i_clk,
  input  wire                   i_rst,
  // Register access from the management frame engine
  input  wire                   i_acc_valid,
  input  wire                   i_acc_write,
  input  wire [4:0]             i_acc_phy_addr,
  input  wire [4:0]             i_acc_reg_addr,
  input  wire [15:0]            i_acc_wdata,
  output reg                    o_acc_done,
  output reg                    o_acc_hit,
  output reg  [15:0]            o_acc_rdata,
  // Media converter mode
  input  wire                   i_center_mode,
  input  wire                   i_center_addr_valid,
  input  wire [4:0]             i_center_phy_addr,
  // Port status and control mirrors
  input  wire [7*NUM_PORTS-1:0] i_port_status,
  input  wire [NUM_PORTS-1:0]   i_far_end_fault,
  input  wire [NUM_PORTS-1:0]   i_neg_ability,
  input  wire [NUM_PORTS-1:0]   i_ctl_adv_wr,
  input  wire [5*NUM_PORTS-1:0] i_ctl_adv,
  // Advertised bits towards port control
  output wire [5*NUM_PORTS-1:0] o_adv_bits,
  output wire [NUM_PORTS-1:0]   o_adv_wr
);

  wire [16*NUM_PORTS-1:0] basic_status;
  wire [16*NUM_PORTS-1:0] adv_img;
  wire [16*NUM_PORTS-1:0] partner_img;
  wire [NUM_PORTS-1:0]    port_sel;
  wire                    reg_known;
  wire [NUM_PORTS-1:0]    adv_wr;
  reg  [15:0]             rdata_next;
  integer                 k;

  ////////////////////////////////////////////////////////////////////////////
  // PHY address decode to a one-hot port select
  function [NUM_PORTS-1:0] port_decode;
    input [4:0] phy_addr;
    input       center;
    input       center_valid;
    input [4:0] center_addr;
    integer     n;
    begin
      port_decode = {NUM_PORTS{1'b0}};
      if (center) begin
        if (center_valid && (phy_addr == center_addr)) begin
          port_decode[0] = 1'b1;                                  // R15
        end
      end else begin
        for (n = 0; n < NUM_PORTS; n = n + 1) begin
          if (phy_addr == (`PMS_PHY_ADDR_PORT1 + n[4:0])) begin
            port_decode[n] = 1'b1;                                // R14
          end
        end
      end
    end
  endfunction

  assign port_sel  = port_decode(i_acc_phy_addr, i_center_mode,
                                 i_center_addr_valid, i_center_phy_addr);
  assign reg_known = (i_acc_reg_addr >= `PMS_REG_BASIC_STATUS) &&
                     (i_acc_reg_addr <= `PMS_REG_PARTNER);
  assign adv_wr    = port_sel & {NUM_PORTS{i_acc_valid && i_acc_write &&
                     (i_acc_reg_addr == `PMS_REG_NEG_ADVERT)}};   // R8 R9

  ////////////////////////////////////////////////////////////////////////////
  // One register group per port
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      pms_port_regs u_port (
        .i_clk           (i_clk),
        .i_rst           (i_rst),
        .i_adv_wr        (adv_wr[g]),
        .i_adv_wdata     (i_acc_wdata),
        .i_ctl_wr        (i_ctl_adv_wr[g]),
        .i_ctl_adv       (i_ctl_adv[5*g+4:5*g]),
        .i_status        (i_port_status[7*g+6:7*g]),
        .i_far_end_fault (i_far_end_fault[g]),
        .i_neg_ability   (i_neg_ability[g]),
        .o_basic_status  (basic_status[16*g+15:16*g]),
        .o_adv_reg       (adv_img[16*g+15:16*g]),
        .o_partner_reg   (partner_img[16*g+15:16*g]),
        .o_adv_bits      (o_adv_bits[5*g+4:5*g]),
        .o_adv_wr        (o_adv_wr[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data select; unknown register numbers read 0
  always @* begin
    rdata_next = 16'h0000;
    for (k = 0; k < NUM_PORTS; k = k + 1) begin
      if (port_sel[k]) begin
        if (i_acc_reg_addr == `PMS_REG_BASIC_STATUS) begin
          rdata_next = basic_status[16*k +: 16];                 // R1 R2 R3
        end else if (i_acc_reg_addr == `PMS_REG_IDENT_UPPER) begin
          rdata_next = `PMS_IDENT_UPPER_VAL;                      // R7
        end else if (i_acc_reg_addr == `PMS_REG_IDENT_LOWER) begin
          rdata_next = `PMS_IDENT_LOWER_VAL;                      // R7
        end else if (i_acc_reg_addr == `PMS_REG_NEG_ADVERT) begin
          rdata_next = adv_img[16*k +: 16];                       // R12
        end else if (i_acc_reg_addr == `PMS_REG_PARTNER) begin
          rdata_next = partner_img[16*k +: 16];                   // R10 R11
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access answer, one cycle after the request
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_acc_done  <= 1'b0;
      o_acc_hit   <= 1'b0;
      o_acc_rdata <= 16'h0000;
    end else begin
      o_acc_done <= i_acc_valid;
      if (i_acc_valid) begin
        o_acc_hit   <= (|port_sel) & reg_known;                   // R15
        o_acc_rdata <= i_acc_write ? 16'h0000 : rdata_next;       // R13
      end
    end
  end

endmodule // pms_phy_mgmt_status_regs

`default_nettype wire

// [tb/pms_phy_mgmt_checker.sv]
// Assertions on the ports of the PHY management register block
`timescale 1ns/1ns
`default_nettype none
`include "pms_phy_mgmt_regs.vh"
module pms_phy_mgmt_checker #(
  parameter NUM_PORTS = 2
) (
  // All ports of the block, watched only
  input wire                   i_clk,
  input wire                   i_rst,
  input wire                   i_acc_valid,
  input wire                   i_acc_write,
  input wire [4:0]             i_acc_phy_addr,
  input wire [4:0]             i_acc_reg_addr,
  input wire [15:0]            i_acc_wdata,
  input wire                   o_acc_done,
  input wire                   o_acc_hit,
  input wire [15:0]            o_acc_rdata,
  input wire                   i_center_mode,
  input wire                   i_center_addr_valid,
  input wire [4:0]             i_center_phy_addr,
  input wire [7*NUM_PORTS-1:0] i_port_status,
  input wire [NUM_PORTS-1:0]   i_far_end_fault,
  input wire [NUM_PORTS-1:0]   i_neg_ability,
  input wire [NUM_PORTS-1:0]   i_ctl_adv_wr,
  input wire [5*NUM_PORTS-1:0] i_ctl_adv,
  input wire [5*NUM_PORTS-1:0] o_adv_bits,
  input wire [NUM_PORTS-1:0]   o_adv_wr
);
  reg       w_reg;
  reg [4:0] pa_reg;
  reg [4:0] ra_reg;
  wire      rd = o_acc_done & o_acc_hit & ~w_reg;
  wire      rdp = rd & (pa_reg == 5'h01);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Last taken access, for judging its answer
  always @(posedge i_clk) begin
    w_reg <= i_acc_write;
    pa_reg <= i_acc_phy_addr;
    ra_reg <= i_acc_reg_addr;
  end
  property p_done; i_acc_valid |=> o_acc_done; endproperty
  a_done: assert property (p_done) else $error("no answer one cycle after access");
  property p_idle; !i_acc_valid |=> !o_acc_done; endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_bs; rd && ra_reg == 5'h01 |-> o_acc_rdata[15:6] == 10'h1e0
    && o_acc_rdata[1:0] == 2'h0; endproperty
  a_bs: assert property (p_bs) else $error("basic status fixed bits wrong");
  property p_mir; rdp && ra_reg == 5'h01 |-> o_acc_rdata[5:2] == {$past(i_port_status[6], 2),
    $past(i_far_end_fault[0], 2), $past(i_neg_ability[0], 2), $past(i_port_status[5], 2)};
  endproperty
  a_mir: assert property (p_mir) else $error("basic status mirror wrong");
  property p_lp; rdp && ra_reg == 5'h05 |-> o_acc_rdata == {5'h00, $past(i_port_status[4], 2),
    1'b0, $past(i_port_status[3:0], 2), 5'h00}; endproperty
  a_lp: assert property (p_lp) else $error("partner ability wrong");
  property p_id; rd && (ra_reg == 5'h02 || ra_reg == 5'h03) |-> o_acc_rdata ==
    (ra_reg == 5'h02 ? `PMS_IDENT_UPPER_VAL : `PMS_IDENT_LOWER_VAL); endproperty
  a_id: assert property (p_id) else $error("identifier word wrong");
  property p_adv; rd && ra_reg == 5'h04 |-> o_acc_rdata[15:11] == 5'h00
    && !o_acc_rdata[9] && o_acc_rdata[4:0] == 5'h01; endproperty
  a_adv: assert property (p_adv) else $error("advertisement fixed bits wrong");
  property p_miss; o_acc_done && (ra_reg == 5'h00 || ra_reg > 5'h05) |->
    !o_acc_hit && o_acc_rdata == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped register answered");
  property p_wr; i_acc_valid && i_acc_write && i_acc_phy_addr == 5'h01 && i_acc_reg_addr == 5'h04
    && !i_center_mode && !i_ctl_adv_wr[0] |=>
    o_adv_bits[4:0] == {$past(i_acc_wdata[10]), $past(i_acc_wdata[8:5])}; endproperty
  a_wr: assert property (p_wr) else $error("advertisement write lost");
  property p_ctr; i_center_mode && i_acc_valid &&
    (!i_center_addr_valid || i_acc_phy_addr != i_center_phy_addr) |=> !o_acc_hit;
  endproperty
  a_ctr: assert property (p_ctr) else $error("unprogrammed address answered in center mode");
  c_wr: cover property (p_wr);
  c_ctr: cover property (i_center_mode && i_acc_valid && i_acc_phy_addr == 5'h02);
  c_mir: cover property (rdp && ra_reg == 5'h01);
endmodule // pms_phy_mgmt_checker
`default_nettype wire

// [tb/pms_mgmt_station.sv]
// Management station model issuing single register accesses
`timescale 1ns/1ns
`default_nettype none
module pms_mgmt_station (
  // Clock
  input  wire         i_clk,
  // Access request
  output logic        o_valid,
  output logic        o_write,
  output logic [4:0]  o_phy,
  output logic [4:0]  o_reg,
  output logic [15:0] o_wdata
);
  // Idle bus at time zero
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_phy = 5'h00;
    o_reg = 5'h00;
    o_wdata = 16'h0000;
  end
  // Request held over its taking edge; released data inverted, never stale
  task automatic access(input logic w, input logic [4:0] p, input logic [4:0] r,
                        input logic [15:0] d);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_write = w;
    o_phy = p;
    o_reg = r;
    o_wdata = d;
    @(posedge i_clk);
    @(negedge i_clk);
    o_valid = 1'b0;
    o_wdata = ~d;
  endtask
endmodule // pms_mgmt_station
`default_nettype wire

// [tb/pms_phy_mgmt_status_regs_tb.sv]
// Self-checking bench for the PHY management register block
`timescale 1ns/1ns
`default_nettype none
module pms_phy_mgmt_status_regs_tb;
  logic i_clk, i_rst, cm, cav, done, hit, v, w;
  logic [4:0] cpa, pa, ra;
  logic [15:0] wd, rdata;
  logic [13:0] pst;
  logic [1:0] fef, nab, cwr, cw, advw;
  logic [9:0] cad, advb;
  logic [4:0] adv [2];
  int errors, n_checks, cyc, seed;
  pms_mgmt_station stn (.i_clk(i_clk), .o_valid(v), .o_write(w), .o_phy(pa), .o_reg(ra),
    .o_wdata(wd));
  pms_phy_mgmt_status_regs #(.NUM_PORTS(2)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_acc_valid(v), .i_acc_write(w), .i_acc_phy_addr(pa), .i_acc_reg_addr(ra),
    .i_acc_wdata(wd), .o_acc_done(done), .o_acc_hit(hit), .o_acc_rdata(rdata),
    .i_center_mode(cm), .i_center_addr_valid(cav), .i_center_phy_addr(cpa),
    .i_port_status(pst), .i_far_end_fault(fef), .i_neg_ability(nab), .i_ctl_adv_wr(cwr),
    .i_ctl_adv(cad), .o_adv_bits(advb), .o_adv_wr(advw));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Cycle ceiling against hangs
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reference model of one access, then compare with the block
  task automatic acc(input logic wr, input logic [4:0] p, input logic [4:0] r,
                     input logic [15:0] d);
    int k;
    logic h;
    logic [15:0] e;
    logic [1:0] ew;
    k = (p == 5'h02 && !cm) ? 1 : 0;
    h = cm ? (cav && p == cpa) : (p == 5'h01 || p == 5'h02);
    h = h && r >= 5'h01 && r <= 5'h05;
    e = 16'h0000;
    if (h && !wr) begin
      case (r)
        5'h01: e = {5'h0f, 5'h00, pst[7*k+6], fef[k], nab[k], pst[7*k+5], 2'h0};
        5'h02: e = `PMS_IDENT_UPPER_VAL;
        5'h03: e = `PMS_IDENT_LOWER_VAL;
        5'h04: e = {5'h00, adv[k][4], 1'b0, adv[k][3:0], 5'h01};
        default: e = {5'h00, pst[7*k+4], 1'b0, pst[7*k+3 -: 4], 5'h00};
      endcase
    end
    if (h && wr && r == 5'h04) adv[k] = {d[10], d[8:5]};
    ew = (h && wr && r == 5'h04) ? 2'(1 << k) : 2'h0;
    stn.access(wr, p, r, d);
    chk("done", 16'h0001, {15'h0000, done});
    chk("hit", {15'h0000, h}, {15'h0000, hit});
    chk("rdata", e, rdata);
    chk("adv_bits", {6'h00, adv[1], adv[0]}, {6'h00, advb});
    chk("adv_wr", {14'h0000, ew}, {14'h0000, advw});
  endtask
  initial begin
    {errors, n_checks, cyc} = 0;
    {cm, cav, cpa, pst, fef, cwr, cad} = 0;
    nab = 2'h3;
    adv = '{5'h1f, 5'h1f};
    i_rst = 1'b1;
    seed = $urandom(32'h91719c02);
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    // Reset image of every register at four addresses
    for (int p = 0; p < 4; p++) for (int r = 0; r < 8; r++) acc(0, p, r, 16'h0000);
    // Random mirrors, control updates, modes and accesses
    repeat (400) begin
      pst = 14'($urandom);
      fef = 2'($urandom);
      nab = 2'($urandom);
      cm = ($urandom % 4) == 0;
      cav = 1'($urandom);
      cpa = 5'($urandom % 4);
      if ($urandom % 4 == 0) begin
        cw = 2'($urandom);
        cwr = cw;
        cad = 10'($urandom);
        @(negedge i_clk);
        cwr = 2'h0;
        for (int k = 0; k < 2; k++) if (cw[k]) adv[k] = cad[5*k +: 5];
      end
      acc(1'($urandom), 5'($urandom % 4), 5'($urandom % 8), 16'($urandom));
    end
    // Mid-run reset: advertised bits return to all ones at both ports
    @(negedge i_clk);
    cm = 1'b0;
    i_rst = 1'b1;
    adv = '{5'h1f, 5'h1f};
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    for (int p = 1; p < 3; p++) acc(0, p, 5'h04, 16'h0000);
    conclude();
  end
endmodule // pms_phy_mgmt_status_regs_tb
bind pms_phy_mgmt_status_regs pms_phy_mgmt_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);
`default_nettype wire
